// ---- nprd_top.sv ----
// nprd_top: serial NAND page program, page load and buffer read sequencer
// assumes spi pins asynchronous to clk, spi period of at least 8 clk cycles
// Behaviour
// - program execute writes buffer into addressed page
// - program starts at select release; busy meanwhile
// - finished program clears write enable latch
// - protected target page refuses program execute
// - 2112 byte buffer; spare bytes fixed with ecc
// - page load copies page into buffer
// - page load self-timed; busy until buffer filled
// - any number of buffer reads per load in buffer mode; a continuous read starts a load of the next page
// - basic read: data after 32 bits
// - single line output on falling edge, msb first
// - read address advances after each byte
// - buffer mode stops at end, then floats
// - continuous mode rolls into next page
// - fast read: 32 bits buffer, 40 continuous
// - extended fast read: data after 48 bits
// - dual read drives two lines per clock
`timescale 1ns/1ps
module nprd_top
	import nprd_pkg::*;
(
	input wire logic clk, // system clock, 250 MHz
	input wire logic rst_n, // sync reset, active low
	input wire logic spi_sel_n, // spi select, active low
	input wire logic spi_clk, // spi serial clock
	input wire logic data_line_zero_in, // serial input line level
	output logic data_line_zero_out, // line zero drive value
	output logic data_line_zero_oe, // line zero drive enable
	output logic data_line_one_out, // line one drive value
	output logic data_line_one_oe, // line one drive enable
	input wire logic buf_mode, // 1 buffer mode, 0 continuous
	input wire logic ecc_enable, // internal ecc on
	input wire nprd_prot_type prot, // protection bits
	input wire logic wel_set, // pulse: set write enable latch
	output logic write_enable_latch, // write enable latch
	output logic busy, // internal cycle running
	output logic prog_refused, // pulse: program refused
	output logic arr_cmd_valid, // array command valid
	output nprd_arr_cmd_type arr_cmd, // array command
	input wire logic arr_cmd_ready, // array command ready
	output logic arr_wvalid, // program byte valid
	output logic [7:0] arr_wdata, // program byte
	input wire logic arr_wready, // program byte ready
	input wire logic arr_done, // pulse: program finished
	input wire logic arr_rvalid, // page byte valid
	input wire logic [7:0] arr_rdata, // page byte
	output logic arr_rready // page byte ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	function automatic logic prot_hit(input nprd_prot_type p, input logic [15:0] page);
		logic [2:0] bp;
		logic [10:0] span;
		logic [10:0] blk;
		bp = {p.protect_field_bit2, p.protect_field_bit1, p.protect_field_bit0};
		blk = {1'b0, page[15:BLOCK_LSB]};
		if (bp == BP_NONE) span = '0;
		else if (bp == BP_ALL) span = BLOCK_COUNT;
		else span = PROT_UNIT << (bp - BITS_ONE);
		prot_hit = p.protect_top_bottom ? (blk < span) : (blk >= BLOCK_COUNT - span);
	endfunction : prot_hit

	// ------------------------------------------------
	// pin synchronisers and edge detect
	// ------------------------------------------------
	logic sel_s1, sel_s2, sel_s3, sck_s1, sck_s2, sck_s3, din_s1, din_s2;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel_s1 <= 1'b1;
			sel_s2 <= 1'b1;
			sel_s3 <= 1'b1;
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			din_s1 <= 1'b0;
			din_s2 <= 1'b0;
		end else begin
			sel_s1 <= spi_sel_n;
			sel_s2 <= sel_s1;
			sel_s3 <= sel_s2;
			sck_s1 <= spi_clk;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			din_s1 <= data_line_zero_in;
			din_s2 <= din_s1;
		end
	end
	wire sel_act = !sel_s2;
	wire sel_start = !sel_s2 && sel_s3;
	wire frame_end = sel_s2 && !sel_s3;
	wire rise = sel_act && sck_s2 && !sck_s3;
	wire fall = sel_act && !sck_s2 && sck_s3;

	// ------------------------------------------------
	// command shift-in
	// ------------------------------------------------
	logic [6:0] bitcnt;
	logic [15:0] sh_in;
	logic [7:0] opcode;
	logic [11:0] cmd_col;
	logic [15:0] cmd_page;
	logic frame_ok;
	wire [15:0] next_word = {sh_in[14:0], din_s2};
	always_ff @(posedge clk) begin
		if (!rst_n || sel_start) begin
			bitcnt <= '0;
		end else if (rise && bitcnt != CNT_MAX) begin
			bitcnt <= bitcnt + CNT_ONE;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sh_in <= '0;
			opcode <= '0;
			cmd_col <= '0;
			cmd_page <= '0;
			frame_ok <= 1'b0;
		end else begin
			// frames opened while busy are dropped
			if (sel_start) frame_ok <= !busy;
			if (rise) sh_in <= next_word;
			if (rise && bitcnt == CNT_OPCODE) opcode <= next_word[7:0];
			if (rise && bitcnt == CNT_COL) cmd_col <= next_word[11:0];
			if (rise && bitcnt == CNT_PAGE) cmd_page <= next_word;
		end
	end

	// ------------------------------------------------
	// decode
	// ------------------------------------------------
	wire is_read = (opcode == OP_READ) || (opcode == OP_FAST) || (opcode == OP_FAST_EXT) || (opcode == OP_DUAL);
	wire is_fast = (opcode == OP_FAST) || (opcode == OP_DUAL);
	wire [6:0] rd_len = (opcode == OP_FAST_EXT) ? LEN_EXT :
		((is_fast && !buf_mode) ? LEN_FAST : LEN_STD);
	wire rd_go = rise && frame_ok && is_read && (bitcnt == rd_len - CNT_ONE);
	nprd_state_type st, next_st;
	logic bg, next_bg;
	// exact length and select release needed
	wire start_exec = frame_end && frame_ok && (st == ST_IDLE) && (bitcnt == LEN_STD);
	wire hit = prot_hit(prot, cmd_page);
	wire start_prog = start_exec && (opcode == OP_PROG_EXEC) && !hit;
	wire refuse_prog = start_exec && (opcode == OP_PROG_EXEC) && hit;
	wire start_load = start_exec && (opcode == OP_PAGE_LOAD);

	// ------------------------------------------------
	// buffer read and output shifter
	// ------------------------------------------------
	logic rd_active, rd_buf, rd_dual;
	logic [11:0] rd_col;
	logic [15:0] rd_page;
	logic [15:0] ld_page;
	logic [2:0] bits_left;
	logic [7:0] sh_out;
	logic [7:0] pre;
	logic one_oe, zero_oe;
	logic [7:0] dbuf [BUF_BYTES];
	wire rd_stop = rd_buf && (rd_col >= BUF_END);
	wire load_byte = fall && rd_active && (bits_left == '0) && !rd_stop;
	wire wrap = load_byte && !rd_buf && (rd_col == BUF_LAST);
	wire [11:0] next_col = (rd_col == BUF_LAST) ? (rd_buf ? BUF_END : COL_ZERO) : rd_col + COL_ONE;
	wire [11:0] rd_idx = (rd_col < BUF_END) ? rd_col : COL_ZERO;
	wire start_bg = (st == ST_IDLE) && rd_active && sel_act && !rd_buf && (rd_page == ld_page);
	always_ff @(posedge clk) begin
		if (!rst_n || frame_end) rd_active <= 1'b0;
		else if (rd_go) rd_active <= 1'b1;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_col <= '0;
			rd_page <= '0;
			rd_buf <= 1'b1;
			rd_dual <= 1'b0;
		end else if (rd_go) begin
			rd_buf <= buf_mode;
			rd_dual <= (opcode == OP_DUAL);
			rd_col <= buf_mode ? cmd_col : COL_ZERO;
			rd_page <= ld_page;
		end else if (load_byte) begin
			rd_col <= next_col;
			if (wrap) rd_page <= rd_page + PAGE_ONE;
		end
	end
	always_ff @(posedge clk) begin
		pre <= dbuf[rd_idx];
	end
	always_ff @(posedge clk) begin
		if (!rst_n || frame_end) begin
			sh_out <= '0;
			bits_left <= '0;
			one_oe <= 1'b0;
			zero_oe <= 1'b0;
		end else if (fall && rd_active) begin
			if (bits_left != '0) begin
				sh_out <= rd_dual ? {sh_out[5:0], 2'h0} : {sh_out[6:0], 1'h0};
				bits_left <= bits_left - BITS_ONE;
			end else if (rd_stop) begin
				one_oe <= 1'b0;
				zero_oe <= 1'b0;
			end else begin
				sh_out <= pre;
				bits_left <= rd_dual ? BITS_DUAL : BITS_SINGLE;
				one_oe <= 1'b1;
				zero_oe <= rd_dual;
			end
		end
	end
	assign data_line_one_out = sh_out[7];
	assign data_line_one_oe = one_oe;
	assign data_line_zero_out = sh_out[6];
	assign data_line_zero_oe = zero_oe;

	// ------------------------------------------------
	// internal cycle sequencer
	// ------------------------------------------------
	logic [11:0] wr_idx;
	logic [11:0] prog_idx;
	logic [15:0] prog_page;
	logic ld_valid, ld_ready, pg_ready;
	logic [7:0] ld_data;
	wire ld_pop = ld_valid && ld_ready;
	wire pg_valid = (st == ST_PROG);
	wire pg_push = pg_valid && pg_ready;
	// spare bytes filled for the ecc engine
	wire [7:0] pg_src = (ecc_enable && prog_idx >= USER_END) ? SPARE_FILL : dbuf[prog_idx];
	// background fill never overtakes the reader
	wire wr_allow = !bg || !rd_active || (rd_page == ld_page) || (wr_idx < rd_col);
	assign ld_ready = (st == ST_LOAD) && wr_allow;
	wire prog_done = (st == ST_PROG_WAIT) && arr_done;

	always_comb begin
		next_st = st;
		case (st)
			ST_IDLE: begin
				if (start_prog) next_st = ST_PROG_CMD;
				else if (start_load || start_bg) next_st = ST_LOAD_CMD;
			end
			ST_LOAD_CMD: if (arr_cmd_ready) next_st = ST_LOAD;
			ST_LOAD: if (ld_pop && wr_idx == BUF_LAST) next_st = ST_IDLE;
			ST_PROG_CMD: if (arr_cmd_ready) next_st = ST_PROG;
			ST_PROG: if (pg_push && prog_idx == BUF_LAST) next_st = ST_PROG_WAIT;
			ST_PROG_WAIT: if (arr_done) next_st = ST_IDLE;
			default: next_st = ST_IDLE;
		endcase
	end
	always_comb begin
		next_bg = bg;
		if (start_load) next_bg = 1'b0;
		else if (start_bg) next_bg = 1'b1;
		else if (next_st == ST_IDLE) next_bg = 1'b0;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= ST_IDLE;
			bg <= 1'b0;
			busy <= 1'b0;
			ld_page <= '0;
			prog_page <= '0;
		end else begin
			st <= next_st;
			bg <= next_bg;
			busy <= (next_st != ST_IDLE) && !next_bg;
			if (start_load) ld_page <= cmd_page;
			else if (start_bg) ld_page <= ld_page + PAGE_ONE;
			if (start_prog) prog_page <= cmd_page;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n || st == ST_LOAD_CMD) wr_idx <= '0;
		else if (ld_pop) wr_idx <= wr_idx + COL_ONE;
	end
	always_ff @(posedge clk) begin
		if (!rst_n || st == ST_PROG_CMD) prog_idx <= '0;
		else if (pg_push) prog_idx <= prog_idx + COL_ONE;
	end
	always_ff @(posedge clk) begin
		// page bytes land in the buffer
		if (ld_pop) dbuf[wr_idx] <= ld_data;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			write_enable_latch <= 1'b0;
			prog_refused <= 1'b0;
		end else begin
			prog_refused <= refuse_prog;
			if (wel_set) write_enable_latch <= 1'b1;
			else if (prog_done) write_enable_latch <= 1'b0;
		end
	end
	assign arr_cmd_valid = (st == ST_LOAD_CMD) || (st == ST_PROG_CMD);
	// program command carries the latched page
	assign arr_cmd = '{write: (st == ST_PROG_CMD), page: (st == ST_PROG_CMD) ? prog_page : ld_page};

	nprd_buf2 #(.W(8), .DEPTH(2)) u_load_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(arr_rvalid),
		.in_data(arr_rdata),
		.in_ready(arr_rready),
		.out_valid(ld_valid),
		.out_data(ld_data),
		.out_ready(ld_ready)
	);
	nprd_buf2 #(.W(8), .DEPTH(2)) u_prog_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(pg_valid),
		.in_data(pg_src),
		.in_ready(pg_ready),
		.out_valid(arr_wvalid),
		.out_data(arr_wdata),
		.out_ready(arr_wready)
	);

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	a_prog_page: assert property (arr_cmd_valid && st == ST_PROG_CMD |-> arr_cmd.write && arr_cmd.page == prog_page)
		else $error("program command page wrong");
	a_busy_cause: assert property ($rose(busy) |-> $past(frame_end))
		else $error("busy rose without select release");
	a_wel_clear: assert property (prog_done && !wel_set |=> !write_enable_latch && !busy)
		else $error("latch not cleared after program");
	a_prot_refuse: assert property (refuse_prog |=> st == ST_IDLE && prog_refused && !busy)
		else $error("protected program not refused");
	a_spare_fill: assert property (pg_valid && ecc_enable && prog_idx >= USER_END |-> pg_src == SPARE_FILL)
		else $error("spare byte not filled");
	a_load_cmd: assert property (start_load |=> st == ST_LOAD_CMD && arr_cmd_valid && !arr_cmd.write && busy)
		else $error("page load not issued");
	a_load_done: assert property (ld_pop && wr_idx == BUF_LAST && !bg |=> st == ST_IDLE && !busy)
		else $error("busy after buffer filled");
	a_read_start: assert property (rd_go |=> rd_active && !busy)
		else $error("read not started");
	a_msb_first: assert property (load_byte && !rd_dual |=> sh_out == $past(pre) && data_line_one_oe)
		else $error("output byte not loaded msb first");
	a_col_adv: assert property (load_byte && rd_col != BUF_LAST |=> rd_col == $past(rd_col) + COL_ONE)
		else $error("column did not advance");
	a_buf_float: assert property (fall && rd_active && rd_stop && bits_left == '0 |=> !data_line_one_oe)
		else $error("output not floated at buffer end");
	a_cont_wrap: assert property (wrap |=> rd_col == COL_ZERO && rd_page == $past(rd_page) + PAGE_ONE)
		else $error("continuous read did not roll over");
	a_dual_lines: assert property (load_byte && rd_dual |=> data_line_zero_oe && data_line_one_oe)
		else $error("dual read not on two lines");
	a_short_frame: assert property (frame_end && st == ST_IDLE && bitcnt < LEN_STD |=> st == ST_IDLE)
		else $error("short frame started a cycle");
endmodule : nprd_top

// ---- nprd_pkg.sv ----
// nprd_pkg: constants and types shared by the serial NAND page sequencer
// assumes a byte-wide array port and a 2112-byte page buffer
package nprd_pkg;
	// ------------------------------------------------
	// page buffer geometry
	// ------------------------------------------------
	localparam int BUF_BYTES = 2112;
	localparam logic [11:0] BUF_END = 12'h840;
	localparam logic [11:0] BUF_LAST = 12'h83F;
	localparam logic [11:0] USER_END = 12'h800;
	localparam logic [11:0] COL_ZERO = 12'h000;
	localparam logic [11:0] COL_ONE = 12'h001;
	localparam logic [7:0] SPARE_FILL = 8'hFF;
	localparam logic [15:0] PAGE_ONE = 16'h0001;
	// ------------------------------------------------
	// opcodes
	// ------------------------------------------------
	localparam logic [7:0] OP_PROG_EXEC = 8'h10;
	localparam logic [7:0] OP_PAGE_LOAD = 8'h13;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_FAST_EXT = 8'h0C;
	localparam logic [7:0] OP_DUAL = 8'h3B;
	// ------------------------------------------------
	// serial bit counts (rising edges in a frame, falling edges per output byte)
	// ------------------------------------------------
	localparam logic [6:0] CNT_OPCODE = 7'h07;
	localparam logic [6:0] CNT_COL = 7'h17;
	localparam logic [6:0] CNT_PAGE = 7'h1F;
	localparam logic [6:0] LEN_STD = 7'h20;
	localparam logic [6:0] LEN_FAST = 7'h28;
	localparam logic [6:0] LEN_EXT = 7'h30;
	localparam logic [6:0] CNT_MAX = 7'h7F;
	localparam logic [6:0] CNT_ONE = 7'h01;
	localparam logic [2:0] BITS_SINGLE = 3'h7;
	localparam logic [2:0] BITS_DUAL = 3'h3;
	localparam logic [2:0] BITS_ONE = 3'h1;
	// ------------------------------------------------
	// block protection
	// ------------------------------------------------
	localparam int BLOCK_LSB = 6;
	localparam logic [10:0] BLOCK_COUNT = 11'h400;
	localparam logic [10:0] PROT_UNIT = 11'h010;
	localparam logic [2:0] BP_NONE = 3'h0;
	localparam logic [2:0] BP_ALL = 3'h7;
	// ------------------------------------------------
	// types
	// ------------------------------------------------
	typedef struct packed {
		logic protect_top_bottom;
		logic protect_field_bit2;
		logic protect_field_bit1;
		logic protect_field_bit0;
	} nprd_prot_type;
	typedef struct packed {
		logic write;
		logic [15:0] page;
	} nprd_arr_cmd_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LOAD_CMD = 3'b001,
		ST_LOAD = 3'b010,
		ST_PROG_CMD = 3'b011,
		ST_PROG = 3'b100,
		ST_PROG_WAIT = 3'b101
	} nprd_state_type;
endpackage : nprd_pkg

// ---- nprd_buf2.sv ----
// nprd_buf2: small valid/ready fifo, two entries by default
// assumes both sides on clk; full and empty are exact
`timescale 1ns/1ps
module nprd_buf2 #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, active low
	input wire logic in_valid, // fill side valid
	input wire logic [W-1:0] in_data, // fill side data
	output logic in_ready, // fill side ready
	output logic out_valid, // drain side valid
	output logic [W-1:0] out_data, // drain side data
	input wire logic out_ready // drain side ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic push;
	logic pop;
	logic [AW-1:0] next_wp;
	logic [AW-1:0] next_rp;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (cnt != CNT_FULL);
	assign out_valid = (cnt != '0);
	assign out_data = mem[rp];
	assign next_wp = (wp == PTR_LAST) ? '0 : wp + AW'(1);
	assign next_rp = (rp == PTR_LAST) ? '0 : rp + AW'(1);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			if (push) begin
				wp <= next_wp;
			end
			if (pop) begin
				rp <= next_rp;
			end
			if (push && !pop) begin
				cnt <= cnt + (AW + 1)'(1);
			end else if (pop && !push) begin
				cnt <= cnt - (AW + 1)'(1);
			end
		end
	end
endmodule : nprd_buf2

// ---- nprd_array_model.sv ----
// nprd_array_model: behavioural flash array behind the sequencer array port
// assumes nprd_top drives the port on clk; samples at negedge, drives at posedge
`timescale 1ns/1ps
module nprd_array_model
	import nprd_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, active low
	input wire logic arr_cmd_valid, // command valid
	input wire nprd_arr_cmd_type arr_cmd, // command
	output logic arr_cmd_ready, // command ready
	input wire logic arr_wvalid, // program byte valid
	input wire logic [7:0] arr_wdata, // program byte
	output logic arr_wready, // program byte ready
	output logic arr_done, // program finished pulse
	output logic arr_rvalid, // page byte valid
	output logic [7:0] arr_rdata, // page byte
	input wire logic arr_rready, // page byte ready
	output int cmd_cnt, // commands taken
	output int load_cnt, // loads completed
	output int wr_cnt, // program bytes taken
	output int spare_ff, // spare bytes equal to ffh
	output logic [15:0] last_page, // last command page
	output logic [7:0] wr_first // first program byte
);
	nprd_arr_cmd_type cmd;
	int n;
	logic take;
	function automatic logic [7:0] nprd_pat(input logic [15:0] pg, input logic [11:0] col);
		return col[7:0] ^ {col[11:8], pg[3:0]};
	endfunction : nprd_pat
	initial begin
		{arr_cmd_ready, arr_wready, arr_done, arr_rvalid, arr_rdata} = '0;
		{cmd_cnt, load_cnt, wr_cnt, spare_ff} = '0;
		{last_page, wr_first} = '0;
		forever begin
			@(negedge clk);
			if (rst_n && arr_cmd_valid === 1'b1) begin
				cmd = arr_cmd;
				@(posedge clk) arr_cmd_ready <= 1'b1;
				@(posedge clk) arr_cmd_ready <= 1'b0;
				cmd_cnt++;
				last_page = cmd.page;
				n = 0;
				if (cmd.write) begin
					// stall every other cycle while taking the page
					while (n < BUF_BYTES) begin
						@(negedge clk);
						if (arr_wvalid && arr_wready) begin
							if (n == 0) wr_first = arr_wdata;
							if (n >= 2048 && arr_wdata === 8'hFF) spare_ff++;
							n++;
						end
						@(posedge clk) arr_wready <= (n < BUF_BYTES) ? ~arr_wready : 1'b0;
					end
					wr_cnt = n;
					repeat (16) @(posedge clk);
					arr_done <= 1'b1;
					@(posedge clk) arr_done <= 1'b0;
				end else begin
					arr_rvalid <= 1'b1;
					arr_rdata <= nprd_pat(cmd.page, 12'h000);
					while (n < BUF_BYTES) begin
						@(negedge clk) take = arr_rvalid && arr_rready;
						@(posedge clk);
						if (take) begin
							n++;
							arr_rvalid <= 1'b0;
							arr_rdata <= ~arr_rdata;
						end else if (!arr_rvalid) begin
							arr_rvalid <= 1'b1;
							arr_rdata <= nprd_pat(cmd.page, 12'(n));
						end
					end
					load_cnt++;
				end
			end
		end
	end
endmodule : nprd_array_model

// ---- nprd_top_tb_top.sv ----
// nprd_top_tb_top: self-checking bench, spi host tasks against nprd_top
// assumes nprd_array_model on the array port; spi period 32 ns, mode 0
`timescale 1ns/1ps
module nprd_top_tb_top
	import nprd_pkg::*;
;
	logic clk, rst_n, spi_sel_n, spi_clk, host_d0, buf_mode, ecc_enable, wel_set;
	nprd_prot_type prot;
	logic zero_out, zero_oe, one_out, one_oe, latch, busy, refused;
	logic cmd_valid, cmd_ready, wvalid, wready, done, rvalid, rready;
	nprd_arr_cmd_type cmd;
	logic [7:0] wdata, rdata, wr_first;
	logic [15:0] last_page;
	wire line_zero = zero_oe ? zero_out : host_d0;
	// pull-up level while the device floats line one
	wire line_one = one_oe ? one_out : 1'b1;
	int err_total, checked, refused_cnt, cycles, cmd_cnt, load_cnt, wr_cnt, spare_ff;
	logic [7:0] rd [0:3];
	nprd_top dut_u (.clk(clk), .rst_n(rst_n), .spi_sel_n(spi_sel_n), .spi_clk(spi_clk),
		.data_line_zero_in(line_zero), .data_line_zero_out(zero_out), .data_line_zero_oe(zero_oe),
		.data_line_one_out(one_out), .data_line_one_oe(one_oe), .buf_mode(buf_mode),
		.ecc_enable(ecc_enable), .prot(prot), .wel_set(wel_set), .write_enable_latch(latch),
		.busy(busy), .prog_refused(refused), .arr_cmd_valid(cmd_valid), .arr_cmd(cmd),
		.arr_cmd_ready(cmd_ready), .arr_wvalid(wvalid), .arr_wdata(wdata), .arr_wready(wready),
		.arr_done(done), .arr_rvalid(rvalid), .arr_rdata(rdata), .arr_rready(rready));
	nprd_array_model arr_u (.clk(clk), .rst_n(rst_n), .arr_cmd_valid(cmd_valid), .arr_cmd(cmd),
		.arr_cmd_ready(cmd_ready), .arr_wvalid(wvalid), .arr_wdata(wdata), .arr_wready(wready),
		.arr_done(done), .arr_rvalid(rvalid), .arr_rdata(rdata), .arr_rready(rready),
		.cmd_cnt(cmd_cnt), .load_cnt(load_cnt), .wr_cnt(wr_cnt), .spare_ff(spare_ff),
		.last_page(last_page), .wr_first(wr_first));
	// ------------------------------------------------
	// checking and reporting
	// ------------------------------------------------
	function automatic logic [7:0] nprd_pat(input logic [15:0] pg, input logic [11:0] col);
		return col[7:0] ^ {col[11:8], pg[3:0]};
	endfunction : nprd_pat
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t byte %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : cmp1
	task automatic cmpi(input int got, input int exp);
		checked++;
		if (got != exp) begin
			err_total++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : cmpi
	task automatic summarize;
		$display("err_total=%0d checked=%0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// ------------------------------------------------
	// spi host
	// ------------------------------------------------
	// select frames each instruction
	task automatic spi_frame(input logic [47:0] lead, input int nlead, input int nb, input bit dual);
		logic [7:0] b;
		b = 8'h00;
		@(posedge clk) spi_sel_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = nlead - 1; i >= 0; i--) begin
			spi_clk <= 1'b0;
			host_d0 <= lead[i];
			repeat (4) @(posedge clk);
			spi_clk <= 1'b1;
			repeat (4) @(posedge clk);
		end
		host_d0 <= ~lead[0];
		for (int k = 0; k < nb; k++) begin
			for (int j = 0; j < (dual ? 4 : 8); j++) begin
				spi_clk <= 1'b0;
				repeat (4) @(posedge clk);
				spi_clk <= 1'b1;
				repeat (3) @(posedge clk);
				@(negedge clk) b = dual ? {b[5:0], line_one, line_zero} : {b[6:0], line_one};
				@(posedge clk);
			end
			rd[k] = b;
		end
		spi_clk <= 1'b0;
		repeat (4) @(posedge clk);
		spi_sel_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : spi_frame
	task automatic rd_chk(input logic [47:0] lead, input int nlead, input int nb, input bit dual,
		input logic [11:0] col, input logic [15:0] pg);
		spi_frame(lead, nlead, nb, dual);
		for (int k = 0; k < nb; k++)
			cmp8(rd[k], (col + k < BUF_BYTES) ? nprd_pat(pg, col + 12'(k)) : 8'hFF);
	endtask : rd_chk
	task automatic wait_busy(input logic v);
		for (int n = 0; n < 8000 && busy !== v; n++)
			@(negedge clk);
		cmp1(busy, v);
	endtask : wait_busy
	task automatic wait_loads(input int v);
		for (int n = 0; n < 8000 && load_cnt != v; n++)
			@(negedge clk);
		cmpi(load_cnt, v);
	endtask : wait_loads
	// ------------------------------------------------
	// clock, timeout, sequence
	// ------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (refused === 1'b1) refused_cnt <= refused_cnt + 1;
		if (cycles == 60000) begin
			err_total++;
			$display("[ERR] %0t timeout", $time);
			summarize();
		end
	end
	initial begin
		{err_total, checked, refused_cnt, cycles} = '0;
		{rst_n, spi_clk, host_d0, ecc_enable, wel_set} = '0;
		{spi_sel_n, buf_mode} = 2'b11;
		prot = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		cmp1(busy, 1'b0);
		cmp1(latch, 1'b0);
		cmp1(one_oe, 1'b0);
		cmp1(cmd_valid, 1'b0);
		cmp1(rready, 1'b1);
		cmp1(wvalid, 1'b0);
		spi_frame({8'h13, 8'h00, 16'h0005}, 32, 0, 0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		cmpi(last_page, 5);
		rd_chk({8'h03, 16'h083E, 8'h00}, 32, 3, 0, 12'h83E, 16'h0005);
		rd_chk({8'h0B, 16'h0000, 8'h00}, 32, 2, 0, 12'h000, 16'h0005);
		rd_chk({8'h0C, 16'h0005, 24'h000000}, 48, 2, 0, 12'h005, 16'h0005);
		rd_chk({8'h3B, 16'h0007, 8'h00}, 32, 2, 1, 12'h007, 16'h0005);
		rd_chk({8'h03, 16'h0840, 8'h00}, 32, 1, 0, 12'h840, 16'h0005);
		buf_mode <= 1'b0;
		rd_chk({8'h03, 24'h000000}, 32, 2, 0, 12'h000, 16'h0005);
		wait_loads(2);
		cmpi(last_page, 6);
		rd_chk({8'h0C, 40'h0000000000}, 48, 2, 0, 12'h000, 16'h0006);
		wait_loads(3);
		rd_chk({8'h0B, 32'h00000000}, 40, 1, 0, 12'h000, 16'h0007);
		wait_loads(4);
		spi_frame({8'h13, 16'h0009}, 24, 0, 0);
		repeat (40) @(posedge clk);
		cmp1(busy, 1'b0);
		cmpi(cmd_cnt, 4);
		ecc_enable <= 1'b1;
		wel_set <= 1'b1;
		@(posedge clk) wel_set <= 1'b0;
		spi_frame({8'h10, 8'h00, 16'h0042}, 32, 0, 0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		cmp1(latch, 1'b0);
		cmpi(last_page, 16'h0042);
		cmpi(wr_cnt, BUF_BYTES);
		cmpi(spare_ff, 64);
		cmp8(wr_first, nprd_pat(16'h0008, 12'h000));
		prot <= '{1'b0, 1'b1, 1'b1, 1'b1};
		wel_set <= 1'b1;
		@(posedge clk) wel_set <= 1'b0;
		spi_frame({8'h10, 8'h00, 16'h0042}, 32, 0, 0);
		repeat (40) @(posedge clk);
		cmpi(refused_cnt, 1);
		cmp1(busy, 1'b0);
		cmpi(cmd_cnt, 5);
		cmp1(latch, 1'b1);
		summarize();
	end
endmodule : nprd_top_tb_top
